// File: codec_ifs.sv
// interfaces between the sequencer and its two arithmetic helpers
`timescale 1ns/10ps

// block maximum and pulse quantiser signals
interface apcm_if;
	logic [15:0] max_in; // absolute block maximum
	logic [5:0] max_code; // its 6-bit code
	logic [5:0] code_in; // code to decode
	logic [15:0] max_dec; // decoded block maximum
	logic signed [15:0] smp_in; // sample to quantise
	logic [2:0] pulse_code; // its 3-bit code
	logic [2:0] pc_in; // pulse code to reconstruct
	logic signed [15:0] denorm; // denormalised pulse
	modport core(output max_in, code_in, smp_in, pc_in,
		input max_code, max_dec, pulse_code, denorm);
	modport unit(input max_in, code_in, smp_in, pc_in,
		output max_code, max_dec, pulse_code, denorm);
endinterface : apcm_if

// lag and gain coder signals
interface param_if;
	logic signed [15:0] gain_in; // q15 gain from the lag search
	logic [1:0] gain_code; // coded gain
	logic [1:0] gcode_in; // gain code to decode
	logic [15:0] gain_dec; // decoded q15 gain
	logic [6:0] lag_in; // lag from the lag search
	logic [6:0] lag_code; // coded lag
	modport core(output gain_in, gcode_in, lag_in,
		input gain_code, gain_dec, lag_code);
	modport unit(input gain_in, gcode_in, lag_in,
		output gain_code, gain_dec, lag_code);
endinterface : param_if

// File: ltp_codec_asserts.sv
// port-level assertions for the sub-segment codec
`timescale 1ns/10ps

module ltp_codec_asserts (
	input logic CLK,
	input logic RSTN,
	input logic START,
	input logic MODE,
	input logic [6:0] LAG,
	input logic [1:0] IN_GAIN_CODE,
	input logic [1:0] IN_GRID_CODE,
	input logic READY,
	input logic SAMPLE_VALID,
	input logic SAMPLE_READY,
	input logic OUT_VALID,
	input logic PAR_VALID,
	input logic [6:0] LAG_CODE,
	input logic [1:0] GAIN_CODE,
	input logic [1:0] GRID_CODE
);
	// ****************
	// helper state
	// ****************
	logic [5:0] taken; // samples accepted this segment
	logic [5:0] run; // length of the current output burst
	logic dec_seg; // segment in flight is a decode
	logic seen; // a segment was started since reset
	logic [6:0] lat_lag; // parameters captured with start
	logic [1:0] lat_gain;
	logic [1:0] lat_grid;
	wire take = START && READY; // accepted start
	wire smp_take = SAMPLE_VALID && SAMPLE_READY; // accepted sample

	// the sample counter restarts at every accepted start; the burst counter restarts whenever OUT_VALID is low
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			taken <= 6'h00;
			run <= 6'h00;
			dec_seg <= 1'b0;
			seen <= 1'b0;
			lat_lag <= 7'h00;
			lat_gain <= 2'h0;
			lat_grid <= 2'h0;
		end else begin
			taken <= take ? 6'h00 : taken + {5'h00, smp_take};
			run <= OUT_VALID ? run + 6'h01 : 6'h00;
			if (take) begin
				dec_seg <= MODE;
				seen <= 1'b1;
				lat_lag <= LAG;
				lat_gain <= IN_GAIN_CODE;
				lat_grid <= IN_GRID_CODE;
			end
		end
	end

	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RSTN);

	// ****************
	// assertions
	// ****************
	chk_start_busy: assert property (take |=> !READY)
		else $error("ready stayed high after an accepted start");
	chk_enc_samples: assert property (
		take && MODE == ltp_pkg::MODE_ENC |=> SAMPLE_READY)
		else $error("encode start did not request samples");
	chk_sample_count: assert property (
		$fell(SAMPLE_READY) |-> taken == 6'h28)
		else $error("sample request closed after wrong count");
	chk_dec_latency: assert property (
		take && MODE == ltp_pkg::MODE_DEC |-> ##2 OUT_VALID)
		else $error("decode output did not begin on time");
	chk_out_burst: assert property (
		$fell(OUT_VALID) |-> run == 6'h28)
		else $error("output burst is not forty samples");
	chk_lag_range: assert property (
		PAR_VALID |-> LAG_CODE >= 7'h28 && LAG_CODE <= 7'h78)
		else $error("lag code outside its legal range");
	chk_dec_codes: assert property (
		$rose(READY) && seen && dec_seg |-> LAG_CODE == lat_lag
		&& GAIN_CODE == lat_gain && GRID_CODE == lat_grid && !PAR_VALID)
		else $error("decode codes differ from received ones");
	chk_enc_params: assert property (
		$rose(READY) && seen && !dec_seg |-> PAR_VALID)
		else $error("encode end without parameter strobe");

	cov_enc: cover property (take && MODE == ltp_pkg::MODE_ENC);
	cov_dec: cover property (take && MODE == ltp_pkg::MODE_DEC);
	cov_grid: cover property (PAR_VALID && GRID_CODE == 2'h2);
endmodule : ltp_codec_asserts

bind rpe_ltp_subframe_codec ltp_codec_asserts ltp_codec_asserts_i (
	.CLK(CLK), .RSTN(RSTN), .START(START), .MODE(MODE), .LAG(LAG),
	.IN_GAIN_CODE(IN_GAIN_CODE), .IN_GRID_CODE(IN_GRID_CODE),
	.READY(READY), .SAMPLE_VALID(SAMPLE_VALID),
	.SAMPLE_READY(SAMPLE_READY), .OUT_VALID(OUT_VALID),
	.PAR_VALID(PAR_VALID), .LAG_CODE(LAG_CODE), .GAIN_CODE(GAIN_CODE),
	.GRID_CODE(GRID_CODE));

// File: ltp_param_codec.sv
// combinational lag and gain coder and decoder
`timescale 1ns/10ps

module ltp_param_codec (
	param_if.unit bus
);

	// ******************************************************
	// lag: the code is the lag itself, held inside the legal span
	// ******************************************************
	assign bus.lag_code = (bus.lag_in < ltp_pkg::LAG_MIN) ? ltp_pkg::LAG_MIN :
		(bus.lag_in > ltp_pkg::LAG_MAX) ? ltp_pkg::LAG_MAX :
		bus.lag_in;

	// ******************************************************
	// gain: three decision levels, upper limit inclusive
	// ******************************************************
	assign bus.gain_code = (bus.gain_in <= ltp_pkg::GAIN_DL0) ? 2'h0 :
		(bus.gain_in <= ltp_pkg::GAIN_DL1) ? 2'h1 :
		(bus.gain_in <= ltp_pkg::GAIN_DL2) ? 2'h2 : 2'h3;

	// same table serves encoder and decoder so both stay in step
	assign bus.gain_dec = (bus.gcode_in == 2'h0) ? ltp_pkg::GAIN_QL0 :
		(bus.gcode_in == 2'h1) ? ltp_pkg::GAIN_QL1 :
		(bus.gcode_in == 2'h2) ? ltp_pkg::GAIN_QL2 :
		ltp_pkg::GAIN_QL3;

endmodule : ltp_param_codec

// File: ltp_pkg.sv
// constants and types shared by the sub-segment long-term / pulse codec
package ltp_pkg;

	// ******************************************************
	// segmentation and counts
	// ******************************************************
	localparam logic [5:0] SEG_LAST = 6'h27; // last sample index, 40 per segment
	localparam logic [3:0] TAP_LAST = 4'ha; // last weighting tap index
	localparam logic [3:0] GRID_LAST = 4'hc; // last pulse index, 13 per grid
	localparam logic [1:0] GM_LAST = 2'h3; // last candidate grid
	localparam logic [8:0] HIST_N = 9'h0a0; // history ring length
	localparam logic [7:0] BASE_LAST = 8'h78; // last segment start in the ring
	localparam logic [7:0] SEG_STEP = 8'h28; // ring advance per segment
	localparam logic [5:0] WF_SHIFT_IN = 6'h05; // centre offset of the filter

	// ******************************************************
	// lag and gain coding
	// ******************************************************
	localparam logic [6:0] LAG_MIN = 7'h28; // shortest legal lag
	localparam logic [6:0] LAG_MAX = 7'h78; // longest legal lag
	localparam logic signed [15:0] GAIN_DL0 = 16'sh199a; // 0.2 in q15
	localparam logic signed [15:0] GAIN_DL1 = 16'sh4000; // 0.5 in q15
	localparam logic signed [15:0] GAIN_DL2 = 16'sh6666; // 0.8 in q15
	localparam logic [15:0] GAIN_QL0 = 16'h0ccd; // 0.10 in q15
	localparam logic [15:0] GAIN_QL1 = 16'h2ccd; // 0.35 in q15
	localparam logic [15:0] GAIN_QL2 = 16'h5333; // 0.65 in q15
	localparam logic [15:0] GAIN_QL3 = 16'h7fff; // 1.00 in q15

	// ******************************************************
	// weighting filter, symmetric taps scaled by 2^13
	// ******************************************************
	localparam logic signed [15:0] WF_TAPS [0:10] = '{
		-16'sh0086, -16'sh0176, 16'sh0000, 16'sh0806, 16'sh166d,
		16'sh2000,
		16'sh166d, 16'sh0806, 16'sh0000, -16'sh0176, -16'sh0086};
	localparam logic signed [31:0] RND13 = 32'sh00001000; // half lsb at 2^13
	localparam logic signed [31:0] RND15 = 32'sh00004000; // half lsb at 2^15
	localparam logic [15:0] XMAX_SMALL = 16'h0200; // end of linear region

	// ******************************************************
	// operating mode and sequencer states
	// ******************************************************
	localparam logic MODE_ENC = 1'h0;
	localparam logic MODE_DEC = 1'h1;
	typedef enum logic [3:0] {
		ST_IDLE, ST_LOAD, ST_LTA, ST_WF, ST_EN, ST_MAX, ST_QX, ST_PQ,
		ST_SYN, ST_DONE
	} state_t;

endpackage : ltp_pkg

// File: residual_source.sv
// residual sample source in place of the short-term analysis stage
`timescale 1ns/10ps

module residual_source (
	input logic clk,
	input logic rstn,
	input logic ready, // codec wants a sample
	input logic gap, // stall one cycle after each sample
	input logic signed [15:0] data [0:39],
	output logic signed [15:0] smp,
	output logic valid
);
	int idx = 0; // next sample of the segment
	logic took; // sample accepted at this edge
	initial begin
		valid = 1'b0;
		smp = 16'sh0000;
	end
	// hold each sample until accepted; a released line shows junk
	always @(posedge clk) begin
		took = valid && ready;
		#1;
		if (!rstn || (took && gap)) begin
			if (took) idx = (idx + 1) % 40;
			if (!rstn) idx = 0;
			valid = 1'b0;
			smp = ~smp;
		end else begin
			if (took) idx = (idx + 1) % 40;
			valid = 1'b1;
			smp = data[idx];
		end
	end
endmodule : residual_source

// File: rpe_apcm.sv
// combinational adaptive pcm quantiser for block maximum and pulses
`timescale 1ns/10ps

module rpe_apcm (
	apcm_if.unit bus
);

	// ******************************************************
	// block maximum: linear below 512, then octave segments of 8
	// ******************************************************
	function automatic logic [5:0] max_encode(input logic [15:0] v);
		logic [3:0] msb;
		logic [15:0] top;
		msb = 4'h9;
		for (int b = 10; b < 15; b++) begin
			if (v[b])
				msb = 4'(b);
		end
		top = v >> (msb - 4'h3);
		if (v < ltp_pkg::XMAX_SMALL)
			return {2'h0, v[8:5]};
		return {3'(msb - 4'h7), top[2:0]};
	endfunction : max_encode

	// decoded value is the upper limit of the code's interval
	function automatic logic [15:0] max_decode(input logic [5:0] c);
		logic [16:0] up;
		// widen before adding and shifting: 4-bit and 3-bit sums would wrap
		up = (17'({1'h1, c[2:0]}) + 17'h00001) << (4'(c[5:3]) + 4'h4);
		if (c < 6'h10)
			return {7'h00, c[3:0], 5'h1f};
		return 16'(up - 17'h00001);
	endfunction : max_decode

	// ******************************************************
	// pulses: 4*s against t*max, t from -3 to 3, no divider needed
	// ******************************************************
	function automatic logic [2:0] pulse_encode(input logic signed [15:0] s,
		input logic [15:0] d);
		logic signed [19:0] s4;
		logic signed [19:0] lim;
		logic [2:0] c;
		s4 = {s[15], s[15], s, 2'h0};
		c = 3'h0;
		for (int t = 1; t < 8; t++) begin
			lim = $signed(20'(t - 4)) * $signed({4'h0, d});
			if (s4 >= lim)
				c = 3'(t);
		end
		return c;
	endfunction : pulse_encode

	// level (2c-7)*4096 times max over 2^15, rounded
	function automatic logic signed [15:0] pulse_decode(input logic [2:0] c,
		input logic [15:0] d);
		logic signed [4:0] lvl;
		logic signed [21:0] p;
		lvl = $signed({1'h0, c, 1'h0}) - 5'sh07;
		p = lvl * $signed({1'h0, d}) + 22'sh000004;
		return 16'(p >>> 3);
	endfunction : pulse_decode

	assign bus.max_code = max_encode(bus.max_in);
	assign bus.max_dec = max_decode(bus.code_in);
	assign bus.pulse_code = pulse_encode(bus.smp_in, bus.max_dec);
	assign bus.denorm = pulse_decode(bus.pc_in, bus.max_dec);

endmodule : rpe_apcm

// File: rpe_ltp_subframe_codec.sv
// sub-segment long-term prediction and pulse excitation codec
`timescale 1ns/10ps
// How it works
// - lag 40..120 sent as 7-bit itself
// - decoder uses received lag code unchanged
// - gain coded 2 bits at 0.2/0.5/0.8
// - gain codes map to 0.10/0.35/0.65/1.00
// - output residual minus long-term estimate per sample
// - estimate is history at lag times gain
// - synthesis adds estimate to reconstructed residual
// - symmetric 11-tap weighting filter, centre 8192
// - forty central outputs, outside inputs are zero
// - four grids of 13, every third sample
// - pick grid with largest energy
// - grid position sent as 2 bits
// - block maximum coded in 6 bits
// - log intervals, decode to interval upper limit
// - normalise by decoded maximum
// - 3-bit uniform pulse codes, 8192 steps
// - pulse level times decoded maximum
// - pulses every third slot, zeros between
// - decoder feeds excitation into synthesis
// - keep last 160 reconstructed samples

module rpe_ltp_subframe_codec (
	input wire logic CLK,
	input wire logic RSTN,
	input wire logic START, // begin one sub-segment
	input wire logic MODE, // 0 encode, 1 decode
	input wire logic [6:0] LAG, // lag, or lag code when decoding
	input wire logic signed [15:0] GAIN, // q15 gain when encoding
	input wire logic [1:0] IN_GAIN_CODE, // decoder parameters
	input wire logic [1:0] IN_GRID_CODE,
	input wire logic [5:0] IN_XMAX_CODE,
	input wire logic [38:0] IN_PULSE_CODES,
	output logic READY, // START is taken while high
	input wire logic signed [15:0] SAMPLE_IN, // short-term residual
	input wire logic SAMPLE_VALID,
	output logic SAMPLE_READY,
	output logic signed [15:0] OUT_SAMPLE, // residual or reconstruction
	output logic OUT_VALID,
	output logic PAR_VALID, // encoder parameters ready
	output logic [6:0] LAG_CODE,
	output logic [1:0] GAIN_CODE,
	output logic [1:0] GRID_CODE,
	output logic [5:0] XMAX_CODE,
	output logic [38:0] PULSE_CODES
);

	// ******************************************************
	// shared arithmetic
	// ******************************************************
	// clip a wide value into 16 signed bits
	function automatic logic signed [15:0] sat16(input logic signed [31:0] v);
		if (v > 32'sh00007fff)
			return 16'sh7fff;
		if (v < -32'sh00008000)
			return -16'sh8000;
		return 16'(v);
	endfunction : sat16

	// q15 product with rounding
	function automatic logic signed [15:0] mult_r(input logic [15:0] g,
		input logic signed [15:0] s);
		logic signed [31:0] p;
		p = $signed({1'h0, g}) * s + ltp_pkg::RND15;
		return sat16(p >>> 15);
	endfunction : mult_r

	// ******************************************************
	// state and storage
	// ******************************************************
	ltp_pkg::state_t state; // sequencer
	logic mode; // mode latched for the segment
	logic [6:0] lag; // lag in use
	logic [1:0] gcode; // gain code in use
	logic [1:0] grid; // grid in use
	logic [5:0] xcode; // block maximum code in use
	logic [2:0] pulses [0:15]; // 13 used, spare slots keep reads in range
	logic signed [15:0] dbuf [0:39]; // residual, then long-term residual
	logic signed [15:0] xbuf [0:39]; // weighted samples
	logic signed [15:0] hist [0:159]; // reconstruction ring
	logic [7:0] base; // ring slot of current segment start
	logic [5:0] k; // sample counter
	logic [3:0] ti; // tap or pulse counter
	logic [1:0] gm; // candidate grid counter
	logic signed [31:0] acc; // filter accumulator
	logic [35:0] eacc; // energy of current candidate
	logic [35:0] ebest; // best energy so far
	logic [15:0] xmax; // running absolute maximum

	apcm_if apcm();
	param_if par();

	rpe_apcm u_apcm (
		.bus(apcm)
	);

	ltp_param_codec u_par (
		.bus(par)
	);

	// ******************************************************
	// long-term estimate from the history ring
	// ******************************************************
	// lag of at least 40 never reaches the slots being written
	wire [8:0] rd_sum = 9'(base) + 9'(k) + ltp_pkg::HIST_N - 9'(lag);
	wire [7:0] rd_idx = (rd_sum >= ltp_pkg::HIST_N) ?
		8'(rd_sum - ltp_pkg::HIST_N) : 8'(rd_sum);
	wire [7:0] wr_idx = base + 8'(k);
	wire signed [15:0] est = mult_r(par.gain_dec, hist[rd_idx]);
	wire signed [15:0] e_now = sat16(32'(dbuf[k]) - 32'(est));

	// ******************************************************
	// weighting filter tap selection
	// ******************************************************
	wire signed [7:0] wf_n = $signed({2'h0, k}) +
		$signed({2'h0, ltp_pkg::WF_SHIFT_IN}) - $signed({4'h0, ti});
	wire wf_in = (wf_n >= 8'sh00) && (wf_n <= $signed({2'h0,
		ltp_pkg::SEG_LAST}));
	wire signed [15:0] wf_e = wf_in ? dbuf[wf_n[5:0]] : 16'sh0000;
	wire signed [31:0] acc_next = acc + ltp_pkg::WF_TAPS[ti] * wf_e;
	wire signed [15:0] x_rnd = sat16((acc_next + ltp_pkg::RND13) >>> 13);

	// ******************************************************
	// grid energy and selected samples
	// ******************************************************
	wire [5:0] g_idx = 6'(gm) + 6'(ti) * 6'h03;
	wire signed [31:0] g_sq = xbuf[g_idx] * xbuf[g_idx];
	wire [35:0] eacc_next = eacc + 36'(unsigned'(g_sq));
	wire [5:0] s_idx = 6'(grid) + 6'(ti) * 6'h03;
	wire signed [15:0] x_s = xbuf[s_idx];
	// the most negative sample has no positive twin, so it clips
	wire [15:0] abs_s = (x_s == -16'sh8000) ? 16'h7fff :
		(x_s < 16'sh0000) ? 16'(-x_s) : 16'(x_s);

	// ******************************************************
	// excitation slot decode: r/3 by multiply, valid for r below 64
	// ******************************************************
	wire [5:0] r6 = k - 6'(grid);
	wire [11:0] r43 = 12'(r6) * 12'h02b;
	wire [4:0] i3 = r43[11:7];
	wire [5:0] m3 = r6 - 6'(i3) * 6'h03;
	wire on_grid = (k >= 6'(grid)) && (m3 == 6'h00) &&
		(i3 <= 5'(ltp_pkg::GRID_LAST));
	wire signed [15:0] exc = on_grid ? apcm.denorm : 16'sh0000;
	wire signed [15:0] d_rec = sat16(32'(exc) + 32'(est));

	assign apcm.max_in = xmax;
	assign apcm.code_in = xcode;
	assign apcm.smp_in = x_s;
	assign apcm.pc_in = pulses[i3[3:0]];
	assign par.gain_in = GAIN;
	assign par.lag_in = LAG;
	assign par.gcode_in = gcode;

	// ******************************************************
	// storage writes, no reset needed except the history
	// ******************************************************
	// history starts silent so the first segments are repeatable
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			for (int h = 0; h < 160; h++)
				hist[h] <= 16'sh0000;
		end else if (state == ltp_pkg::ST_SYN) begin
			hist[wr_idx] <= d_rec;
		end
	end

	// sample and filter buffers
	always_ff @(posedge CLK) begin
		if (state == ltp_pkg::ST_LOAD && SAMPLE_VALID)
			dbuf[k] <= SAMPLE_IN;
		else if (state == ltp_pkg::ST_LTA)
			dbuf[k] <= e_now;
		if (state == ltp_pkg::ST_WF && ti == ltp_pkg::TAP_LAST)
			xbuf[k] <= x_rnd;
	end

	// ******************************************************
	// sequencer
	// ******************************************************
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			state <= ltp_pkg::ST_IDLE;
			mode <= ltp_pkg::MODE_ENC;
			lag <= ltp_pkg::LAG_MIN;
			gcode <= 2'h0;
			grid <= 2'h0;
			xcode <= 6'h00;
			for (int p = 0; p < 16; p++)
				pulses[p] <= 3'h4;
			base <= 8'h00;
			k <= 6'h00;
			ti <= 4'h0;
			gm <= 2'h0;
			acc <= 32'sh00000000;
			eacc <= 36'h000000000;
			ebest <= 36'h000000000;
			xmax <= 16'h0000;
			READY <= 1'h0;
			SAMPLE_READY <= 1'h0;
			OUT_SAMPLE <= 16'sh0000;
			OUT_VALID <= 1'h0;
			PAR_VALID <= 1'h0;
			LAG_CODE <= 7'h00;
			GAIN_CODE <= 2'h0;
			GRID_CODE <= 2'h0;
			XMAX_CODE <= 6'h00;
			PULSE_CODES <= 39'h0000000000;
		end else begin
			OUT_VALID <= 1'h0;
			PAR_VALID <= 1'h0;
			case (state)
			ltp_pkg::ST_IDLE: begin
				READY <= 1'h1;
				// READY is checked so the first idle cycle after reset takes nothing
				if (START && READY) begin
					READY <= 1'h0;
					mode <= MODE;
					k <= 6'h00;
					if (MODE == ltp_pkg::MODE_ENC) begin
						lag <= par.lag_code;
						gcode <= par.gain_code;
						SAMPLE_READY <= 1'h1;
						state <= ltp_pkg::ST_LOAD;
					end else begin
						lag <= LAG;
						gcode <= IN_GAIN_CODE;
						grid <= IN_GRID_CODE;
						xcode <= IN_XMAX_CODE;
						for (int p = 0; p < 13; p++)
							pulses[p] <= IN_PULSE_CODES[3 * p +: 3];
						state <= ltp_pkg::ST_SYN;
					end
				end
			end
			ltp_pkg::ST_LOAD: begin
				if (SAMPLE_VALID) begin
					k <= k + 6'h01;
					if (k == ltp_pkg::SEG_LAST) begin
						k <= 6'h00;
						SAMPLE_READY <= 1'h0;
						state <= ltp_pkg::ST_LTA;
					end
				end
			end
			ltp_pkg::ST_LTA: begin
				OUT_SAMPLE <= e_now;
				OUT_VALID <= 1'h1;
				k <= k + 6'h01;
				acc <= 32'sh00000000;
				ti <= 4'h0;
				if (k == ltp_pkg::SEG_LAST) begin
					k <= 6'h00;
					state <= ltp_pkg::ST_WF;
				end
			end
			ltp_pkg::ST_WF: begin
				if (ti == ltp_pkg::TAP_LAST) begin
					ti <= 4'h0;
					acc <= 32'sh00000000;
					k <= k + 6'h01;
					if (k == ltp_pkg::SEG_LAST) begin
						k <= 6'h00;
						gm <= 2'h0;
						eacc <= 36'h000000000;
						state <= ltp_pkg::ST_EN;
					end
				end else begin
					acc <= acc_next;
					ti <= ti + 4'h1;
				end
			end
			ltp_pkg::ST_EN: begin
				if (ti == ltp_pkg::GRID_LAST) begin
					ti <= 4'h0;
					eacc <= 36'h000000000;
					// strict compare keeps the lower grid on a tie
					if (gm == 2'h0 || eacc_next > ebest) begin
						ebest <= eacc_next;
						grid <= gm;
					end
					gm <= gm + 2'h1;
					if (gm == ltp_pkg::GM_LAST) begin
						xmax <= 16'h0000;
						state <= ltp_pkg::ST_MAX;
					end
				end else begin
					eacc <= eacc_next;
					ti <= ti + 4'h1;
				end
			end
			ltp_pkg::ST_MAX: begin
				if (abs_s > xmax)
					xmax <= abs_s;
				ti <= ti + 4'h1;
				if (ti == ltp_pkg::GRID_LAST) begin
					ti <= 4'h0;
					state <= ltp_pkg::ST_QX;
				end
			end
			ltp_pkg::ST_QX: begin
				xcode <= apcm.max_code;
				state <= ltp_pkg::ST_PQ;
			end
			ltp_pkg::ST_PQ: begin
				pulses[ti] <= apcm.pulse_code;
				ti <= ti + 4'h1;
				if (ti == ltp_pkg::GRID_LAST) begin
					ti <= 4'h0;
					state <= ltp_pkg::ST_SYN;
				end
			end
			ltp_pkg::ST_SYN: begin
				if (mode == ltp_pkg::MODE_DEC) begin
					OUT_SAMPLE <= d_rec;
					OUT_VALID <= 1'h1;
				end
				k <= k + 6'h01;
				if (k == ltp_pkg::SEG_LAST) begin
					k <= 6'h00;
					state <= ltp_pkg::ST_DONE;
				end
			end
			ltp_pkg::ST_DONE: begin
				base <= (base == ltp_pkg::BASE_LAST) ? 8'h00 :
					base + ltp_pkg::SEG_STEP;
				LAG_CODE <= lag;
				GAIN_CODE <= gcode;
				GRID_CODE <= grid;
				XMAX_CODE <= xcode;
				for (int p = 0; p < 13; p++)
					PULSE_CODES[3 * p +: 3] <= pulses[p];
				PAR_VALID <= (mode == ltp_pkg::MODE_ENC);
				READY <= 1'h1;
				state <= ltp_pkg::ST_IDLE;
			end
			default: begin
				state <= ltp_pkg::ST_IDLE;
			end
			endcase
		end
	end

endmodule : rpe_ltp_subframe_codec

// File: rpe_ltp_subframe_codec_tb_top.sv
// self-checking bench for the sub-segment codec
`timescale 1ns/10ps

module rpe_ltp_subframe_codec_tb_top;
	logic clk = 1'b0, rstn = 1'b0, start = 1'b0, mode = 1'b0, gap = 1'b0;
	logic vld, srdy, ready, ovalid, pvalid;
	logic [6:0] lag = 7'h28, lag_code;
	logic signed [15:0] gain = 16'sh0000, smp, osmp;
	logic [1:0] igc = 2'h0, igr = 2'h0, gc, grc;
	logic [5:0] ixc = 6'h00, xc;
	logic [38:0] ipc = 39'h0, pc, ep;
	logic signed [15:0] data [0:39] = '{default: 16'sh0000};
	logic signed [15:0] got [0:39]; // collected outputs
	int errors = 0, n_checks = 0;
	int hist [0:279]; // expected reconstructed history
	int qlev [0:3] = '{3277, 11469, 21299, 32767};
	logic [6:0] dlag [0:3] = '{7'h28, 7'h28, 7'h50, 7'h78};
	logic [5:0] dxc [0:3] = '{6'h17, 6'h28, 6'h10, 6'h07};
	logic signed [15:0] gtab [0:5] = '{16'sh199a, 16'sh199b, 16'sh4000,
		16'sh4001, 16'sh6666, 16'sh6667};
	logic [1:0] gexp [0:5] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3};
	logic [6:0] ltab [0:5] = '{7'h28, 7'h78, 7'h27, 7'h79, 7'h50, 7'h28};
	logic [6:0] lexp [0:5] = '{7'h28, 7'h78, 7'h28, 7'h78, 7'h50, 7'h28};

	always #2.5 clk = ~clk;

	rpe_ltp_subframe_codec rpe_ltp_subframe_codec_i (.CLK(clk), .RSTN(rstn),
		.START(start), .MODE(mode), .LAG(lag), .GAIN(gain),
		.IN_GAIN_CODE(igc), .IN_GRID_CODE(igr), .IN_XMAX_CODE(ixc),
		.IN_PULSE_CODES(ipc), .READY(ready), .SAMPLE_IN(smp),
		.SAMPLE_VALID(vld), .SAMPLE_READY(srdy), .OUT_SAMPLE(osmp),
		.OUT_VALID(ovalid), .PAR_VALID(pvalid), .LAG_CODE(lag_code),
		.GAIN_CODE(gc), .GRID_CODE(grc), .XMAX_CODE(xc), .PULSE_CODES(pc));
	residual_source residual_source_i (.clk(clk), .rstn(rstn), .ready(srdy),
		.gap(gap), .data(data), .smp(smp), .valid(vld));

	// ****************
	// shared tasks
	// ****************
	task tick; @(posedge clk); #1; endtask : tick
	task check(input logic [38:0] seen, input logic [38:0] exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task complete_run;
		if (errors == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : complete_run
	// ready and pvalid must be cleared in reset; ready rises on the first edge
	task do_reset;
		rstn = 1'b0;
		repeat (16) tick;
		check(ready, 39'h0);
		check(pvalid, 39'h0);
		rstn = 1'b1;
		tick;
		check(ready, 39'h1);
	endtask : do_reset
	task wait_ready;
		for (int w = 0; w < 2000 && ready !== 1'b1; w++) tick;
		check(ready, 39'h1);
	endtask : wait_ready
	task start_seg(input logic m, input logic [6:0] l,
		input logic signed [15:0] g);
		wait_ready;
		mode = m;
		lag = l;
		gain = g;
		start = 1'b1;
		tick;
		start = 1'b0;
	endtask : start_seg
	task collect;
		int n;
		n = 0;
		for (int w = 0; w < 3000 && n < 40; w++) begin
			tick;
			if (ovalid === 1'b1) begin
				got[n] = osmp;
				n++;
			end
		end
		check(39'(n), 39'h28);
	endtask : collect
	task wait_par;
		for (int w = 0; w < 1000 && pvalid !== 1'b1; w++) tick;
		check(pvalid, 39'h1);
	endtask : wait_par

	// ****************
	// scenarios
	// ****************
	// gain decisions at both sides of each level, lag clamping
	task t_gain_codes;
		do_reset;
		for (int i = 0; i < 6; i++) begin
			start_seg(ltp_pkg::MODE_ENC, ltab[i], gtab[i]);
			wait_par;
			check(gc, gexp[i]);
			check(lag_code, lexp[i]);
			for (int k = 0; k < 13; k++) ep[3*k +: 3] = 3'h4;
			if (i == 0) begin
				check(grc, 2'h0);
				check(xc, 6'h00);
				check(pc, ep);
			end
		end
	endtask : t_gain_codes
	// lone pulse of 1000 at slot 20, slow source, empty history
	task t_impulse;
		do_reset;
		data[20] = 16'sh03e8;
		gap = 1'b1;
		start_seg(ltp_pkg::MODE_ENC, 7'h28, 16'sh0000);
		collect;
		for (int k = 0; k < 40; k++)
			check(got[k], (k == 20) ? 16'sh03e8 : 16'sh0000);
		wait_par;
		check(grc, 2'h2);
		check(xc, 6'h17);
		for (int k = 0; k < 13; k++) ep[3*k +: 3] = (k == 6) ? 3'h7 : 3'h4;
		check(pc, ep);
		gap = 1'b0;
		data[20] = 16'sh0000;
	endtask : t_impulse
	function automatic int xmax_dec(input logic [5:0] c);
		int e;
		if (c < 6'h10) return 32 * (int'(c) + 1) - 1;
		e = int'(c >> 3) - 1;
		return (256 << e) + ((int'(c) & 7) + 1) * (32 << e) - 1;
	endfunction : xmax_dec
	// four back-to-back decodes, every gain, grid and pulse code
	task t_decode;
		int n, d, xd, ex, o;
		logic signed [15:0] e16;
		do_reset;
		for (int k = 0; k < 280; k++) hist[k] = 0;
		for (int s = 0; s < 4; s++) begin
			igc = 2'(s);
			igr = 2'(s ^ 1);
			ixc = dxc[s];
			for (int k = 0; k < 13; k++) ipc[3*k +: 3] = 3'(k + 3 * s);
			xd = xmax_dec(ixc);
			start_seg(ltp_pkg::MODE_DEC, dlag[s], 16'sh0000);
			collect;
			for (int k = 0; k < 40; k++) begin
				n = 120 + 40 * s + k;
				o = k - int'(igr);
				ex = 0;
				if (o >= 0 && o < 39 && o % 3 == 0)
					ex = ((2 * int'(ipc[o +: 3]) - 7) * xd + 4) >>> 3;
				d = ex + ((qlev[igc] * hist[n - int'(dlag[s])] + 16384) >>> 15);
				hist[n] = d;
				e16 = 16'(d);
				check(got[k], e16);
			end
			wait_ready;
			check({lag_code, gc, grc}, {dlag[s], igc, igr});
		end
	endtask : t_decode

	initial begin
		t_gain_codes;
		t_impulse;
		t_decode;
		complete_run;
	end
	// cut a hang short well after the expected run length
	initial begin
		#200000;
		errors++;
		complete_run;
	end
endmodule : rpe_ltp_subframe_codec_tb_top
